// File: inc/ebalu_regs.vh
// constants for the eight bit alu and branch unit
`ifndef EBALU_REGS_VH
`define EBALU_REGS_VH
// operation codes (6 bits)
`define EB_OP_NOP 6'h00
`define EB_OP_ADD 6'h01
`define EB_OP_ADC 6'h02
`define EB_OP_ADD_IMMEDIATE_WORD 6'h03
`define EB_OP_SUB 6'h04
`define EB_OP_SUBC 6'h05
`define EB_OP_SBB 6'h06
`define EB_OP_SBBC 6'h07
`define EB_OP_SUBTRACT_IMMEDIATE_WORD 6'h08
`define EB_OP_AND 6'h09
`define EB_OP_ANDC 6'h0A
`define EB_OP_OR 6'h0B
`define EB_OP_ORC 6'h0C
`define EB_OP_XOR 6'h0D
`define EB_OP_COM 6'h0E
`define EB_OP_NEG 6'h0F
`define EB_OP_SBR 6'h10
`define EB_OP_CBR 6'h11
`define EB_OP_INC 6'h12
`define EB_OP_DEC 6'h13
`define EB_OP_TST 6'h14
`define EB_OP_CLR 6'h15
`define EB_OP_SER 6'h16
`define EB_OP_MUL 6'h17
`define EB_OP_MULTIPLY_SIGNED 6'h18
`define EB_OP_MULTIPLY_MIXED_SIGN 6'h19
`define EB_OP_FRACTIONAL_MULTIPLY_UNSIGNED 6'h1A
`define EB_OP_FRACTIONAL_MULTIPLY_SIGNED 6'h1B
`define EB_OP_FRACTIONAL_MULTIPLY_MIXED 6'h1C
`define EB_OP_INDIRECT_JUMP 6'h1D
`define EB_OP_INDIRECT_CALL 6'h1E
`define EB_OP_COMPARE_SKIP_EQUAL 6'h1F
`define EB_OP_CP 6'h20
`define EB_OP_CPC 6'h21
`define EB_OP_CPI 6'h22
`define EB_OP_SKRC 6'h23
`define EB_OP_SKRS 6'h24
`define EB_OP_SKIC 6'h25
`define EB_OP_SKIS 6'h26
`define EB_OP_BRS 6'h27
`define EB_OP_BRC 6'h28
// status flag positions
`define EB_F_C 0
`define EB_F_Z 1
`define EB_F_N 2
`define EB_F_V 3
`define EB_F_S 4
`define EB_F_H 5
`define EB_F_T 6
`define EB_F_I 7
`define EB_FC 0
// constants
`define EB_ONES 8'hFF
`define EB_ZERO 8'h00
`define EB_STATUS_FLAGS_REGISTER_RST 8'h00
`define EB_CYC_ONE 2'h1
`define EB_CYC_TWO 2'h2
`define EB_CYC_THREE 2'h3
`endif

// File: src/ebalu_core.v
// eight bit alu and branch unit datapath
`timescale 1ns/10ps
`include "ebalu_regs.vh"
module ebalu_core #(
  parameter PC_W = 16
) (
  input wire clk,
  input wire rst_n,
  input wire op_valid,
  input wire [5:0] op_code,
  input wire [7:0] rd_val,
  input wire [7:0] rr_val,
  input wire [7:0] rdh_val,
  input wire [7:0] imm_val,
  input wire [2:0] bit_sel,
  input wire [7:0] io_val,
  input wire next_two_word,
  input wire [PC_W-1:0] pc_val,
  input wire [PC_W-1:0] z_ptr,
  input wire [PC_W-1:0] br_offset,
  input wire [7:0] status_flags_register_in,
  output wire op_ready,
  output reg res_we,
  output reg [7:0] res_lo,
  output reg res_hi_we,
  output reg [7:0] res_hi,
  output reg prod_we,
  output reg status_flags_register_we,
  output reg [7:0] status_flags_register_out,
  output reg pc_we,
  output reg [PC_W-1:0] pc_out,
  output reg push_ret,
  output reg done
);

  // =====================================================
  // arithmetic helpers
  // =====================================================
  reg [7:0] r_d;
  reg [7:0] res8;
  reg [15:0] res16;
  reg [15:0] prod;
  reg [7:0] fl;
  reg wr_lo;
  reg wr_hi;
  reg wr_prod;
  reg wr_fl;
  reg jmp;
  reg [PC_W-1:0] tgt;
  reg [1:0] cyc;
  reg skip_c;
  reg take;
  reg ret;
  reg [8:0] sum9;
  reg [4:0] sum5;
  reg [7:0] opb;
  reg cin;
  reg sub;
  reg [16:0] w17;
  reg [PC_W-1:0] skip_pc;

  // busy pipeline for multi-cycle operations
  reg [1:0] cnt_q;
  reg [1:0] cnt_d;
  reg res_we_d;
  reg res_hi_we_d;
  reg prod_we_d;
  reg status_flags_register_we_d;
  reg pc_we_d;
  reg push_d;
  reg done_d;
  reg [7:0] lo_d;
  reg [7:0] hi_d;
  reg [7:0] fl_d;
  reg [PC_W-1:0] pc_d;

  assign op_ready = (cnt_q == 2'h0);

  // =====================================================
  // decode and compute
  // =====================================================
  always @* begin
    r_d = rd_val;
    res8 = `EB_ZERO;
    res16 = 16'h0000;
    prod = 16'h0000;
    fl = status_flags_register_in;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    wr_prod = 1'b0;
    wr_fl = 1'b0;
    jmp = 1'b0;
    tgt = pc_val;
    cyc = `EB_CYC_ONE;
    skip_c = 1'b0;
    take = 1'b0;
    ret = 1'b0;
    sum9 = 9'h000;
    sum5 = 5'h00;
    opb = rr_val;
    cin = 1'b0;
    sub = 1'b0;
    w17 = 17'h00000;
    skip_pc = pc_val + (next_two_word ? {{(PC_W-2){1'b0}}, 2'h3} : {{(PC_W-2){1'b0}}, 2'h2});
    case (op_code)
      `EB_OP_ADD, `EB_OP_ADC: begin
        cin = (op_code == `EB_OP_ADC) & status_flags_register_in[`EB_FC];
        sum9 = {1'b0, r_d} + {1'b0, opb} + {8'h00, cin};
        sum5 = {1'b0, r_d[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
        res8 = sum9[7:0];
        wr_lo = 1'b1;
        wr_fl = 1'b1;
        fl[`EB_FC] = sum9[8];
        fl[`EB_F_H] = sum5[4];
        fl[`EB_F_V] = (r_d[7] == opb[7]) & (res8[7] != r_d[7]);
      end
      `EB_OP_SUB, `EB_OP_SUBC, `EB_OP_SBB, `EB_OP_SBBC, `EB_OP_CP, `EB_OP_CPC, `EB_OP_CPI, `EB_OP_NEG: begin
        sub = 1'b1;
        if ((op_code == `EB_OP_SUBC) || (op_code == `EB_OP_SBBC) || (op_code == `EB_OP_CPI))
          opb = imm_val;
        if (op_code == `EB_OP_NEG) begin
          r_d = `EB_ZERO;
          opb = rd_val;
        end
        cin = ((op_code == `EB_OP_SBB) || (op_code == `EB_OP_SBBC) || (op_code == `EB_OP_CPC)) & status_flags_register_in[`EB_FC];
        sum9 = {1'b0, r_d} - {1'b0, opb} - {8'h00, cin};
        sum5 = {1'b0, r_d[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
        res8 = sum9[7:0];
        wr_lo = (op_code != `EB_OP_CP) && (op_code != `EB_OP_CPC) && (op_code != `EB_OP_CPI);
        wr_fl = 1'b1;
        fl[`EB_FC] = sum9[8];
        fl[`EB_F_H] = sum5[4];
        fl[`EB_F_V] = (r_d[7] != opb[7]) & (res8[7] != r_d[7]);
      end
      `EB_OP_ADD_IMMEDIATE_WORD, `EB_OP_SUBTRACT_IMMEDIATE_WORD: begin
        if (op_code == `EB_OP_ADD_IMMEDIATE_WORD)
          w17 = {1'b0, rdh_val, rd_val} + {9'h000, imm_val};
        else
          w17 = {1'b0, rdh_val, rd_val} - {9'h000, imm_val};
        res16 = w17[15:0];
        res8 = res16[7:0];
        wr_lo = 1'b1;
        wr_hi = 1'b1;
        wr_fl = 1'b1;
        cyc = `EB_CYC_TWO;
        fl[`EB_FC] = w17[16];
        fl[`EB_F_V] = (op_code == `EB_OP_ADD_IMMEDIATE_WORD) ? (~rdh_val[7] & res16[15]) : (rdh_val[7] & ~res16[15]);
      end
      // logic, mask ops, test and clear
      `EB_OP_AND, `EB_OP_ANDC, `EB_OP_OR, `EB_OP_ORC, `EB_OP_XOR, `EB_OP_SBR, `EB_OP_CBR, `EB_OP_TST,
      `EB_OP_CLR: begin
        case (op_code)
          `EB_OP_AND: res8 = r_d & rr_val;
          `EB_OP_ANDC: res8 = r_d & imm_val;
          `EB_OP_OR: res8 = r_d | rr_val;
          `EB_OP_ORC, `EB_OP_SBR: res8 = r_d | imm_val;
          `EB_OP_XOR: res8 = r_d ^ rr_val;
          `EB_OP_CBR: res8 = r_d & (`EB_ONES - imm_val);
          `EB_OP_TST: res8 = r_d & r_d;
          default: res8 = r_d ^ r_d;
        endcase
        wr_lo = (op_code != `EB_OP_TST);
        wr_fl = 1'b1;
        fl[`EB_F_V] = 1'b0;
      end
      `EB_OP_COM: begin
        res8 = `EB_ONES - r_d;
        wr_lo = 1'b1;
        wr_fl = 1'b1;
        fl[`EB_FC] = 1'b1;
        fl[`EB_F_V] = 1'b0;
      end
      `EB_OP_INC, `EB_OP_DEC: begin
        res8 = (op_code == `EB_OP_INC) ? r_d + 8'h01 : r_d - 8'h01;
        wr_lo = 1'b1;
        wr_fl = 1'b1;
        fl[`EB_F_V] = (op_code == `EB_OP_INC) ? (r_d == 8'h7F) : (r_d == 8'h80);
      end
      `EB_OP_SER: begin
        res8 = `EB_ONES;
        wr_lo = 1'b1;
      end
      `EB_OP_MUL, `EB_OP_MULTIPLY_SIGNED, `EB_OP_MULTIPLY_MIXED_SIGN, `EB_OP_FRACTIONAL_MULTIPLY_UNSIGNED, `EB_OP_FRACTIONAL_MULTIPLY_SIGNED, `EB_OP_FRACTIONAL_MULTIPLY_MIXED: begin
        case (op_code)
          `EB_OP_MUL, `EB_OP_FRACTIONAL_MULTIPLY_UNSIGNED: prod = {8'h00, r_d} * {8'h00, rr_val};
          `EB_OP_MULTIPLY_SIGNED, `EB_OP_FRACTIONAL_MULTIPLY_SIGNED: prod = {{8{r_d[7]}}, r_d} * {{8{rr_val[7]}}, rr_val};
          default: prod = {{8{r_d[7]}}, r_d} * {8'h00, rr_val};
        endcase
        fl[`EB_FC] = prod[15];
        if (op_code >= `EB_OP_FRACTIONAL_MULTIPLY_UNSIGNED)
          prod = {prod[14:0], 1'b0};
        wr_prod = 1'b1;
        wr_fl = 1'b1;
        cyc = `EB_CYC_TWO;
        fl[`EB_F_Z] = (prod == 16'h0000);
      end
      `EB_OP_INDIRECT_JUMP, `EB_OP_INDIRECT_CALL: begin
        jmp = 1'b1;
        tgt = z_ptr;
        ret = (op_code == `EB_OP_INDIRECT_CALL);
        cyc = ret ? `EB_CYC_THREE : `EB_CYC_TWO;
      end
      // compare skip, register bit, io bit
      `EB_OP_COMPARE_SKIP_EQUAL, `EB_OP_SKRC, `EB_OP_SKRS, `EB_OP_SKIC, `EB_OP_SKIS: begin
        case (op_code)
          `EB_OP_COMPARE_SKIP_EQUAL: skip_c = (rd_val == rr_val);
          `EB_OP_SKRC: skip_c = ~rr_val[bit_sel];
          `EB_OP_SKRS: skip_c = rr_val[bit_sel];
          `EB_OP_SKIC: skip_c = ~io_val[bit_sel];
          default: skip_c = io_val[bit_sel];
        endcase
        jmp = skip_c;
        tgt = skip_pc;
        cyc = ~skip_c ? `EB_CYC_ONE : (next_two_word ? `EB_CYC_THREE : `EB_CYC_TWO);
      end
      `EB_OP_BRS, `EB_OP_BRC: begin
        take = (op_code == `EB_OP_BRS) ? status_flags_register_in[bit_sel] : ~status_flags_register_in[bit_sel];
        jmp = take;
        tgt = pc_val + br_offset + {{(PC_W-1){1'b0}}, 1'b1};
        cyc = take ? `EB_CYC_TWO : `EB_CYC_ONE;
      end
      default: begin
        cyc = `EB_CYC_ONE;
      end
    endcase
    if (wr_fl && !wr_prod) begin
      if (wr_hi) begin
        fl[`EB_F_Z] = (res16 == 16'h0000);
        fl[`EB_F_N] = res16[15];
      end else begin
        fl[`EB_F_Z] = (res8 == `EB_ZERO);
        // carry-in subtracts and compares keep zero only when still zero
        if ((op_code == `EB_OP_CPC) || (op_code == `EB_OP_SBB) || (op_code == `EB_OP_SBBC))
          fl[`EB_F_Z] = (res8 == `EB_ZERO) & status_flags_register_in[`EB_F_Z];
        fl[`EB_F_N] = res8[7];
      end
      fl[`EB_F_S] = fl[`EB_F_N] ^ fl[`EB_F_V];
    end
  end

  // =====================================================
  // result registers and cycle counter
  // =====================================================
  always @* begin
    cnt_d = (cnt_q != 2'h0) ? cnt_q - 2'h1 : 2'h0;
    res_we_d = 1'b0;
    res_hi_we_d = 1'b0;
    prod_we_d = 1'b0;
    status_flags_register_we_d = 1'b0;
    pc_we_d = 1'b0;
    push_d = 1'b0;
    done_d = (cnt_q == 2'h1);
    lo_d = res_lo;
    hi_d = res_hi;
    fl_d = status_flags_register_out;
    pc_d = pc_out;
    if (op_valid && op_ready) begin
      cnt_d = cyc - 2'h1;
      res_we_d = wr_lo;
      res_hi_we_d = wr_hi;
      prod_we_d = wr_prod;
      status_flags_register_we_d = wr_fl;
      pc_we_d = jmp;
      push_d = ret;
      done_d = (cyc == `EB_CYC_ONE);
      lo_d = wr_prod ? prod[7:0] : res8;
      hi_d = wr_prod ? prod[15:8] : res16[15:8];
      fl_d = fl;
      pc_d = tgt;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      res_we <= 1'b0;
      res_hi_we <= 1'b0;
      prod_we <= 1'b0;
      status_flags_register_we <= 1'b0;
      pc_we <= 1'b0;
      push_ret <= 1'b0;
      done <= 1'b0;
      res_lo <= `EB_ZERO;
      res_hi <= `EB_ZERO;
      status_flags_register_out <= `EB_STATUS_FLAGS_REGISTER_RST;
      pc_out <= {PC_W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
      res_we <= res_we_d;
      res_hi_we <= res_hi_we_d;
      prod_we <= prod_we_d;
      status_flags_register_we <= status_flags_register_we_d;
      pc_we <= pc_we_d;
      push_ret <= push_d;
      done <= done_d;
      res_lo <= lo_d;
      res_hi <= hi_d;
      status_flags_register_out <= fl_d;
      pc_out <= pc_d;
    end
  end

endmodule

// File: tb/ebalu_core_monitor.sv
// concurrent checks on the ports of the alu and branch unit
`timescale 1ns/10ps
`include "ebalu_regs.vh"
module ebalu_chk #(
  parameter PC_W = 16
) (
  input logic clk,
  input logic rst_n,
  input logic op_valid,
  input logic [5:0] op_code,
  input logic [7:0] rd_val,
  input logic [7:0] rr_val,
  input logic [2:0] bit_sel,
  input logic [PC_W-1:0] pc_val,
  input logic [PC_W-1:0] z_ptr,
  input logic [PC_W-1:0] br_offset,
  input logic [7:0] status_flags_register_in,
  input logic op_ready,
  input logic res_we,
  input logic [7:0] res_lo,
  input logic prod_we,
  input logic status_flags_register_we,
  input logic [7:0] status_flags_register_out,
  input logic pc_we,
  input logic [PC_W-1:0] pc_out,
  input logic push_ret,
  input logic done
);
  wire tk = op_valid && op_ready;
  wire mul = op_code >= `EB_OP_MUL && op_code <= `EB_OP_FRACTIONAL_MULTIPLY_MIXED;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====================================================
  // assertions
  a_add_one_cycle: assert property (tk && op_code == `EB_OP_ADD |=>
    res_we && status_flags_register_we && done && res_lo == $past(rd_val) + $past(rr_val)) else $error("add result or timing");
  a_logic_keeps_ch: assert property (tk && op_code == `EB_OP_AND |=>
    done && (status_flags_register_out & 8'h21) == ($past(status_flags_register_in) & 8'h21)) else $error("and altered carry or half carry");
  a_com_value: assert property (tk && op_code == `EB_OP_COM |=>
    res_we && res_lo == 8'hFF - $past(rd_val)) else $error("ones complement value");
  a_neg_value: assert property (tk && op_code == `EB_OP_NEG |=>
    done && res_lo == 8'h00 - $past(rd_val)) else $error("twos complement value");
  a_ser_no_flags: assert property (tk && op_code == `EB_OP_SER |=>
    res_lo == 8'hFF && !status_flags_register_we) else $error("set register touched flags");
  a_mul_two_cycles: assert property (tk && mul |=>
    prod_we && status_flags_register_we && !done && !op_ready ##1 done && op_ready) else $error("multiply timing");
  a_indirect_jump_target: assert property (tk && op_code == `EB_OP_INDIRECT_JUMP |=>
    pc_we && !push_ret && pc_out == $past(z_ptr) ##1 done) else $error("indirect jump");
  a_indirect_call_three: assert property (tk && op_code == `EB_OP_INDIRECT_CALL |=>
    push_ret && !done ##1 !done ##1 done) else $error("indirect call timing");
  a_cmp_no_write: assert property (tk && (op_code == `EB_OP_CP || op_code == `EB_OP_CPI) |=>
    !res_we && status_flags_register_we && done) else $error("compare wrote a register");
  a_branch_taken: assert property (tk && op_code == `EB_OP_BRS && status_flags_register_in[bit_sel] |=>
    pc_we && pc_out == $past(pc_val) + $past(br_offset) + 1'b1 ##1 done) else $error("taken branch");
  a_branch_idle: assert property (tk && op_code == `EB_OP_BRC && status_flags_register_in[bit_sel] |=>
    !pc_we && done) else $error("untaken branch");
  c_mul: cover property (tk && mul);
  c_indirect_call: cover property (tk && op_code == `EB_OP_INDIRECT_CALL);
  c_branch: cover property (tk && op_code == `EB_OP_BRS && status_flags_register_in[bit_sel]);
endmodule
bind ebalu_core ebalu_chk #(.PC_W(PC_W)) u_chk (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
  .op_code(op_code), .rd_val(rd_val), .rr_val(rr_val), .bit_sel(bit_sel), .pc_val(pc_val), .z_ptr(z_ptr),
  .br_offset(br_offset), .status_flags_register_in(status_flags_register_in), .op_ready(op_ready), .res_we(res_we), .res_lo(res_lo),
  .prod_we(prod_we), .status_flags_register_we(status_flags_register_we), .status_flags_register_out(status_flags_register_out), .pc_we(pc_we), .pc_out(pc_out),
  .push_ret(push_ret), .done(done));

// File: tb/ebalu_core_test.sv
// self-checking bench for the alu and branch unit
`timescale 1ns/10ps
`include "ebalu_regs.vh"
module ebalu_core_test;
  logic clk, rst_n, op_valid, next_two_word;
  logic [5:0] op_code;
  logic [7:0] rd_val, rr_val, rdh_val, imm_val, io_val, status_flags_register_in;
  logic [2:0] bit_sel;
  logic [15:0] pc_val, z_ptr, br_offset;
  wire op_ready, res_we, res_hi_we, prod_we, status_flags_register_we, pc_we, push_ret, done;
  wire [7:0] res_lo, res_hi, status_flags_register_out;
  wire [15:0] pc_out;
  logic [5:0] st;
  integer miscompares = 0, n_checks = 0, ncyc, cyc_cnt = 0, b;
  ebalu_core #(.PC_W(16)) uut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .rd_val(rd_val), .rr_val(rr_val), .rdh_val(rdh_val), .imm_val(imm_val), .bit_sel(bit_sel),
    .io_val(io_val), .next_two_word(next_two_word), .pc_val(pc_val), .z_ptr(z_ptr),
    .br_offset(br_offset), .status_flags_register_in(status_flags_register_in), .op_ready(op_ready), .res_we(res_we), .res_lo(res_lo),
    .res_hi_we(res_hi_we), .res_hi(res_hi), .prod_we(prod_we), .status_flags_register_we(status_flags_register_we), .status_flags_register_out(status_flags_register_out),
    .pc_we(pc_we), .pc_out(pc_out), .push_ret(push_ret), .done(done));
  // ====================================================
  // shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // strobes of the first cycle land in st, cycle count in ncyc
  task go(input logic [5:0] op);
    op_code = op;
    op_valid = 1'b1;
    @(posedge clk);
    #1 op_valid = 1'b0;
    st = {res_we, res_hi_we, prod_we, status_flags_register_we, pc_we, push_ret};
    ncyc = 1;
    while (done !== 1'b1 && ncyc < 8) begin
      @(posedge clk);
      #1 ncyc = ncyc + 1;
    end
  endtask
  task alu(input logic [5:0] op, input logic [7:0] a, c, s, r, f, m, input logic w);
    rd_val = a;
    rr_val = c;
    imm_val = c;
    status_flags_register_in = s;
    go(op);
    chk(ncyc, 1);
    chk(st[5], w);
    if (w) chk(res_lo, r);
    chk(st[2], m != 8'h00);
    chk(status_flags_register_out & m, f);
  endtask
  task mul(input logic [5:0] op, input logic [7:0] a, c, input logic [15:0] p, input logic [7:0] f);
    rd_val = a;
    rr_val = c;
    go(op);
    chk(ncyc, 2);
    chk(st[3], 1'b1);
    chk({res_hi, res_lo}, p);
    chk(status_flags_register_out & 8'h03, f);
  endtask
  task br(input logic [5:0] op, input logic t, input logic [15:0] pc, input integer n);
    go(op);
    chk(ncyc, n);
    chk(st[1], t);
    if (t) chk(pc_out, pc);
  endtask
  // ====================================================
  // scenarios
  task t_arith;
    alu(`EB_OP_ADD, 8'h0F, 8'h01, 8'h00, 8'h10, 8'h20, 8'h2F, 1);
    alu(`EB_OP_ADC, 8'hFF, 8'h00, 8'h01, 8'h00, 8'h23, 8'h2F, 1);
    alu(`EB_OP_SUB, 8'h80, 8'h01, 8'h00, 8'h7F, 8'h28, 8'h2F, 1);
    alu(`EB_OP_SUBC, 8'h80, 8'h01, 8'h00, 8'h7F, 8'h28, 8'h2F, 1);
    alu(`EB_OP_SBB, 8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 8'h2F, 1);
    alu(`EB_OP_SBBC, 8'h05, 8'h04, 8'h03, 8'h00, 8'h02, 8'h2F, 1);
    alu(`EB_OP_CP, 8'h80, 8'h01, 8'h00, 8'h00, 8'h28, 8'h2F, 0);
    alu(`EB_OP_CPI, 8'h80, 8'h01, 8'h00, 8'h00, 8'h28, 8'h2F, 0);
    alu(`EB_OP_CPC, 8'h05, 8'h05, 8'h02, 8'h00, 8'h02, 8'h2F, 0);
  endtask
  task t_logic;
    alu(`EB_OP_AND, 8'hF0, 8'h0F, 8'h21, 8'h00, 8'h23, 8'h2F, 1);
    alu(`EB_OP_ANDC, 8'hC3, 8'h96, 8'h21, 8'h82, 8'h25, 8'h2F, 1);
    alu(`EB_OP_OR, 8'hC3, 8'h5A, 8'h21, 8'hDB, 8'h25, 8'h2F, 1);
    alu(`EB_OP_ORC, 8'hC3, 8'h96, 8'h21, 8'hD7, 8'h25, 8'h2F, 1);
    alu(`EB_OP_XOR, 8'hC3, 8'h5A, 8'h21, 8'h99, 8'h25, 8'h2F, 1);
    alu(`EB_OP_SBR, 8'hC3, 8'h96, 8'h21, 8'hD7, 8'h25, 8'h2F, 1);
    alu(`EB_OP_CBR, 8'hC3, 8'h96, 8'h21, 8'h41, 8'h21, 8'h2F, 1);
    alu(`EB_OP_SER, 8'h12, 8'h00, 8'h21, 8'hFF, 8'h00, 8'h00, 1);
  endtask
  task t_unary;
    alu(`EB_OP_COM, 8'h55, 8'h00, 8'h00, 8'hAA, 8'h05, 8'h0F, 1);
    alu(`EB_OP_NEG, 8'h80, 8'h00, 8'h00, 8'h80, 8'h0D, 8'h2F, 1);
    alu(`EB_OP_INC, 8'h7F, 8'h00, 8'h00, 8'h80, 8'h0C, 8'h0E, 1);
    alu(`EB_OP_DEC, 8'h80, 8'h00, 8'h00, 8'h7F, 8'h08, 8'h0E, 1);
    alu(`EB_OP_TST, 8'h80, 8'h00, 8'h00, 8'h80, 8'h04, 8'h0E, 0);
    alu(`EB_OP_CLR, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h02, 8'h0E, 1);
  endtask
  task t_word;
    {rdh_val, rd_val, imm_val, status_flags_register_in} = {24'h7FFF01, 8'h00};
    go(`EB_OP_ADD_IMMEDIATE_WORD);
    chk({ncyc[3:0], st[4], res_hi, res_lo, status_flags_register_out & 8'h1F}, {4'h2, 1'b1, 16'h8000, 8'h0C});
    {rdh_val, rd_val} = 16'h0000;
    go(`EB_OP_SUBTRACT_IMMEDIATE_WORD);
    chk({ncyc[3:0], st[4], res_hi, res_lo, status_flags_register_out & 8'h1F}, {4'h2, 1'b1, 16'hFFFF, 8'h15});
  endtask
  task t_mul;
    mul(`EB_OP_MUL, 8'hFF, 8'hFF, 16'hFE01, 8'h01);
    mul(`EB_OP_MUL, 8'h00, 8'h12, 16'h0000, 8'h02);
    mul(`EB_OP_MULTIPLY_SIGNED, 8'hFF, 8'h02, 16'hFFFE, 8'h01);
    mul(`EB_OP_MULTIPLY_MIXED_SIGN, 8'hFF, 8'hFF, 16'hFF01, 8'h01);
    mul(`EB_OP_FRACTIONAL_MULTIPLY_UNSIGNED, 8'h80, 8'h80, 16'h8000, 8'h00);
    mul(`EB_OP_FRACTIONAL_MULTIPLY_SIGNED, 8'h80, 8'h80, 16'h8000, 8'h00);
    mul(`EB_OP_FRACTIONAL_MULTIPLY_MIXED, 8'hC0, 8'h02, 16'hFF00, 8'h01);
  endtask
  task t_flow;
    z_ptr = 16'h1234;
    br(`EB_OP_INDIRECT_JUMP, 1, 16'h1234, 2);
    chk(st[0], 1'b0);
    br(`EB_OP_INDIRECT_CALL, 1, 16'h1234, 3);
    chk(st[0], 1'b1);
    {pc_val, br_offset, rd_val, rr_val, next_two_word} = {32'h0100FFFE, 16'h5A5A, 1'b1};
    br(`EB_OP_COMPARE_SKIP_EQUAL, 1, 16'h0103, 3);
    rr_val = 8'h5B;
    br(`EB_OP_COMPARE_SKIP_EQUAL, 0, 16'h0000, 1);
    {rr_val, bit_sel, io_val, next_two_word} = {8'h80, 3'h7, 8'h00, 1'b0};
    br(`EB_OP_SKRS, 1, 16'h0102, 2);
    br(`EB_OP_SKRC, 0, 16'h0000, 1);
    br(`EB_OP_SKIC, 1, 16'h0102, 2);
    br(`EB_OP_SKIS, 0, 16'h0000, 1);
    for (b = 0; b < 8; b = b + 1) begin
      bit_sel = b[2:0];
      status_flags_register_in = 8'h01 << b;
      br(`EB_OP_BRS, 1, 16'h00FF, 2);
      br(`EB_OP_BRC, 0, 16'h0000, 1);
      status_flags_register_in = ~status_flags_register_in;
      br(`EB_OP_BRC, 1, 16'h00FF, 2);
      br(`EB_OP_BRS, 0, 16'h0000, 1);
    end
  endtask
  // ====================================================
  // clock, reset, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 2000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end
  initial begin
    {rst_n, op_valid, next_two_word, op_code, bit_sel} = 0;
    {rd_val, rr_val, rdh_val, imm_val, io_val, status_flags_register_in} = 0;
    {pc_val, z_ptr, br_offset} = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    t_arith;
    t_logic;
    t_unary;
    t_word;
    t_mul;
    t_flow;
    tally_and_finish;
  end
endmodule
